// ==== rtl/cscr_pkg.sv ====
// Constants, types and helpers shared by the system control register block
package cscr_pkg;

  // Register offsets on the plain register port
  localparam logic [15:0] CSCR_OFF_RSTC = 16'hED0C;
  localparam logic [15:0] CSCR_OFF_SLPC = 16'hED10;
  localparam logic [15:0] CSCR_OFF_CFGC = 16'hED14;

  // Write key of the reset/interrupt control word and what its field reads as
  localparam logic [15:0] CSCR_WRITE_KEY      = 16'h05FA;
  localparam logic [15:0] CSCR_KEY_READ_VALUE = 16'h0000;

  // Field positions
  localparam int CSCR_KEY_LSB       = 16;
  localparam int CSCR_KEY_MSB       = 31;
  localparam int CSCR_BYTE_ORDER    = 15;
  localparam int CSCR_SYSRST_BIT    = 2;
  localparam int CSCR_CLRACT_BIT    = 1;
  localparam int CSCR_WAKE_ANY_BIT  = 4;
  localparam int CSCR_DEEP_BIT      = 2;
  localparam int CSCR_ONEXIT_BIT    = 1;
  localparam int CSCR_STK_ALIGN_BIT = 9;
  localparam int CSCR_UNALIGN_BIT   = 3;
  localparam int CSCR_STS_ALIGN_BIT = 9;

  // Values after reset and fixed read values
  localparam logic        CSCR_BYTE_ORDER_VAL = 1'b0;
  localparam logic        CSCR_SYSRST_RESET   = 1'b0;
  localparam logic        CSCR_SCR_BIT_RESET  = 1'b0;
  localparam logic [8:0]  CSCR_EXC_NUM_RESET  = 9'h000;
  localparam logic [31:0] CSCR_CFG_VALUE      = 32'h0000_0208;
  localparam logic [31:0] CSCR_RDATA_RESET    = 32'h0000_0000;
  localparam logic [31:0] CSCR_SP_RESET       = 32'h0000_0000;

  // Defaults of widths
  localparam int CSCR_IRQ_NUM = 32;

  // Power state of the core
  typedef enum logic [1:0] {
    CSCR_RUN   = 2'b00,
    CSCR_SLEEP = 2'b01,
    CSCR_WEVT  = 2'b10
  } cscr_power_t;

  // Access size codes: byte, half word, word
  localparam logic [1:0] CSCR_SIZE_BYTE = 2'h0;
  localparam logic [1:0] CSCR_SIZE_HALF = 2'h1;

  // Unaligned access check for a size and the low address bits
  function automatic logic cscr_unaligned(input logic [1:0] size, input logic [1:0] addr);
    logic bad;
    bad = 1'b0;
    if (size == CSCR_SIZE_BYTE) begin
      bad = 1'b0;
    end else if (size == CSCR_SIZE_HALF) begin
      bad = addr[0];
    end else begin
      bad = (addr != 2'h0);
    end
    return bad;
  endfunction

endpackage

// ==== rtl/cscr_wake_if.sv ====
// Signals between the control block and its event latch
`timescale 1ns/1ns
interface cscr_wake_if #(parameter int IRQ_NUM = 32);
  logic               wake_any;   // Disabled interrupts may wake too
  logic [IRQ_NUM-1:0] irq_rise;   // Interrupts that just became pending
  logic [IRQ_NUM-1:0] irq_en;     // Interrupt enables
  logic               snd_evt;    // Send-event instruction
  logic               ext_evt;    // Synchronised external event edge
  logic               wev_enter;  // Wait-for-event instruction issued
  logic               waiting;    // Core sits in wait-for-event
  logic               wake;       // Qualifying event while waiting
  logic               consume;    // Latched event eaten by a new wait
  logic               latched;    // An event is held for the next wait

  modport ctrl (output wake_any, irq_rise, irq_en, snd_evt, ext_evt, wev_enter, waiting,
                input  wake, consume, latched);
  modport latch (input  wake_any, irq_rise, irq_en, snd_evt, ext_evt, wev_enter, waiting,
                 output wake, consume, latched);
endinterface

// ==== rtl/cscr_event_latch.sv ====
// Event qualification and the one-deep event latch for wait-for-event
`timescale 1ns/1ns
module cscr_event_latch
  import cscr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Link to the control block
  cscr_wake_if.latch wk
);

  logic qualify;
  logic latch_q;
  logic latch_d;

  // Events that may wake the core
  always_comb begin
    qualify = (|(wk.irq_rise & (wk.irq_en | {$bits(wk.irq_en){wk.wake_any}})))
              | wk.snd_evt | wk.ext_evt;
  end

  // Wake when waiting, consume a held event on a new wait
  assign wk.wake    = wk.waiting & qualify;
  assign wk.consume = wk.wev_enter & latch_q;
  assign wk.latched = latch_q;

  // Latch next value; a fresh event wins over the consume
  always_comb begin
    latch_d = latch_q;
    if (wk.consume) begin
      latch_d = 1'b0;
    end
    if (qualify && !wk.waiting) begin
      latch_d = 1'b1;
    end
  end

  // Event latch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // An event outside a wait is held; a wait with no fresh event empties the latch
  a_event_held: assert property (@(posedge clock) disable iff (!resetn)
    (qualify && !wk.waiting) |=> wk.latched)
    else $error("event outside wait not held");

  a_latch_consumed: assert property (@(posedge clock) disable iff (!resetn)
    (wk.wev_enter && latch_q && !qualify) |=> !latch_q)
    else $error("held event not consumed by wait");

endmodule // cscr_event_latch

// ==== rtl/cscr_top.sv ====
// System control registers: keyed reset control, sleep control, fixed configuration
// Notes on behaviour
// - Reset control writes need key 0x05FA in bits 31:16; key field reads zero.
// - Byte order bit 15 always reads zero, little-endian.
// - Keyed write of one to bit 2 raises the system reset request.
// - The requested system reset clears the debugger's core-halted flag.
// - Clear-active bit self-clears; only the debug port sets it while halted.
// - Clear-active wipes active exceptions, forces thread mode and exception number zero.
// - Wake-any bit zero: only enabled interrupts or events wake the core.
// - Wake-any bit one: any newly pending interrupt, even disabled, ends a wait-for-event.
// - Qualifying event wakes a waiting core, else is latched for next wait.
// - Send-event instruction or external event also ends the wait.
// - Deep-sleep bit selects ordinary sleep at zero, deep sleep at one.
// - Sleep-after-handler bit one puts core to sleep on return to thread.
// - Stack alignment bit 9 of the configuration word always reads one.
// - Exception entry records alignment padding in bit 9 of saved status.
// - Exception return uses the saved bit to restore stack pointer alignment.
// - Unaligned trap bit reads one; every unaligned access raises hard fault.
`timescale 1ns/1ns
module cscr_top
  import cscr_pkg::*;
#(
  parameter int IRQ_NUM = CSCR_IRQ_NUM
)(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               resetn,
  // Register port
  input  wire logic [15:0]        reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  input  wire logic               reg_from_debug,
  output logic      [31:0]        reg_rdata_q,
  // Debug and reset handshake
  input  wire logic               core_halted,
  output logic                    sys_reset_req_q,
  output logic                    halt_flag_clear_q,
  output logic                    exc_clear_q,
  // Exception number
  input  wire logic               exc_num_load,
  input  wire logic [8:0]         exc_num_in,
  output logic      [8:0]         exception_number_status_q,
  // Interrupts, events and power
  input  wire logic [IRQ_NUM-1:0] irq_pending,
  input  wire logic [IRQ_NUM-1:0] irq_enable,
  input  wire logic               wait_for_event_instr,
  input  wire logic               send_event_instr,
  input  wire logic               ext_event_pin,
  input  wire logic               sleep_instr,
  input  wire logic               handler_to_thread,
  output logic                    wake_q,
  output logic                    low_power_q,
  output logic                    deep_sleep_q,
  // Stack alignment on exception entry and return
  input  wire logic               exc_entry,
  input  wire logic [31:0]        entry_sp,
  input  wire logic               exc_return,
  input  wire logic [31:0]        return_frame_sp,
  input  wire logic [31:0]        return_saved_sts,
  output logic      [31:0]        frame_sp_q,
  output logic                    saved_align_q,
  output logic      [31:0]        restored_sp_q,
  // Data access alignment check
  input  wire logic               acc_valid,
  input  wire logic [1:0]         acc_size,
  input  wire logic [1:0]         acc_addr_lo,
  output logic                    hard_fault_q
);

  cscr_wake_if #(.IRQ_NUM(IRQ_NUM)) wk ();

  logic               wake_any_pending_q;
  logic               deep_sleep_select_q;
  logic               sleep_after_handler_q;
  logic [IRQ_NUM-1:0] irq_pending_q;
  logic               ext_s1_q;
  logic               ext_s2_q;
  logic               ext_s3_q;
  cscr_power_t        pwr_q;
  cscr_power_t        pwr_d;
  logic               key_ok;
  logic               wr_rstc;
  logic               wr_slpc;
  logic               clr_req;
  logic               sleep_enter;
  logic               wfi_wake;
  logic [31:0]        rd_d;

  // Decode of register writes
  assign key_ok   = (reg_wdata[CSCR_KEY_MSB:CSCR_KEY_LSB] == CSCR_WRITE_KEY);
  assign wr_rstc  = reg_write && (reg_addr == CSCR_OFF_RSTC) && key_ok;
  assign wr_slpc  = reg_write && (reg_addr == CSCR_OFF_SLPC);
  assign clr_req  = wr_rstc && reg_wdata[CSCR_CLRACT_BIT]
                    && reg_from_debug && core_halted;

  // Power control word
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_any_pending_q    <= CSCR_SCR_BIT_RESET;
      deep_sleep_select_q   <= CSCR_SCR_BIT_RESET;
      sleep_after_handler_q <= CSCR_SCR_BIT_RESET;
    end else if (wr_slpc) begin
      wake_any_pending_q    <= reg_wdata[CSCR_WAKE_ANY_BIT];
      deep_sleep_select_q   <= reg_wdata[CSCR_DEEP_BIT];
      sleep_after_handler_q <= reg_wdata[CSCR_ONEXIT_BIT];
    end
  end

  // Reset request held until the outer system resets this block
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sys_reset_req_q   <= CSCR_SYSRST_RESET;
      halt_flag_clear_q <= 1'b0;
    end else begin
      halt_flag_clear_q <= 1'b0;
      if (wr_rstc && reg_wdata[CSCR_SYSRST_BIT]) begin
        sys_reset_req_q   <= 1'b1;
        halt_flag_clear_q <= !sys_reset_req_q;
      end
    end
  end

  // Clear-active pulse, self-clearing after one cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      exc_clear_q <= 1'b0;
    end else begin
      exc_clear_q <= clr_req;
    end
  end

  // Exception number; the clear forces zero and thread mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      exception_number_status_q <= CSCR_EXC_NUM_RESET;
    end else if (clr_req) begin
      exception_number_status_q <= CSCR_EXC_NUM_RESET;
    end else if (exc_num_load) begin
      exception_number_status_q <= exc_num_in;
    end
  end

  // External event pin synchroniser and edge stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_event_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Previous pending state for rising detection
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_pending_q <= '0;
    end else begin
      irq_pending_q <= irq_pending;
    end
  end

  // Signals toward the event latch
  assign wk.wake_any  = wake_any_pending_q;
  assign wk.irq_rise  = irq_pending & ~irq_pending_q;
  assign wk.irq_en    = irq_enable;
  assign wk.snd_evt   = send_event_instr;
  assign wk.ext_evt   = ext_s2_q & ~ext_s3_q;
  assign wk.wev_enter = wait_for_event_instr && (pwr_q == CSCR_RUN);
  assign wk.waiting   = (pwr_q == CSCR_WEVT);

  cscr_event_latch u_event_latch (
    .clock  (clock),
    .resetn (resetn),
    .wk     (wk)
  );

  // Sleep entry and wake from ordinary sleep
  assign sleep_enter = sleep_instr || (handler_to_thread && sleep_after_handler_q);
  assign wfi_wake    = |(irq_pending & irq_enable);

  // Power state next value
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      CSCR_RUN: begin
        if (wk.wev_enter && !wk.consume) begin
          pwr_d = CSCR_WEVT;
        end else if (sleep_enter) begin
          pwr_d = CSCR_SLEEP;
        end
      end
      CSCR_SLEEP: begin
        if (wfi_wake) begin
          pwr_d = CSCR_RUN;
        end
      end
      CSCR_WEVT: begin
        if (wk.wake) begin
          pwr_d = CSCR_RUN;
        end
      end
      default: begin
        pwr_d = CSCR_RUN;
      end
    endcase
  end

  // Power state and its outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwr_q        <= CSCR_RUN;
      low_power_q  <= 1'b0;
      deep_sleep_q <= 1'b0;
      wake_q       <= 1'b0;
    end else begin
      pwr_q        <= pwr_d;
      low_power_q  <= (pwr_d != CSCR_RUN);
      deep_sleep_q <= (pwr_d != CSCR_RUN) && deep_sleep_select_q;
      wake_q       <= (pwr_q != CSCR_RUN) && (pwr_d == CSCR_RUN) || wk.consume;
    end
  end

  // Stack alignment on entry and restore on return
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frame_sp_q    <= CSCR_SP_RESET;
      saved_align_q <= 1'b0;
      restored_sp_q <= CSCR_SP_RESET;
    end else begin
      if (exc_entry) begin
        frame_sp_q    <= {entry_sp[31:3], 3'h0};
        saved_align_q <= entry_sp[2];
      end
      if (exc_return) begin
        restored_sp_q <= {return_frame_sp[31:3],
                          return_saved_sts[CSCR_STS_ALIGN_BIT],
                          return_frame_sp[1:0]};
      end
    end
  end

  // Unaligned data accesses always trap
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hard_fault_q <= 1'b0;
    end else begin
      hard_fault_q <= acc_valid && cscr_unaligned(acc_size, acc_addr_lo);
    end
  end

  // Read data multiplexer
  always_comb begin
    rd_d = CSCR_RDATA_RESET;
    if (reg_read) begin
      case (reg_addr)
        CSCR_OFF_RSTC: begin
          rd_d[CSCR_KEY_MSB:CSCR_KEY_LSB] = CSCR_KEY_READ_VALUE;
          rd_d[CSCR_BYTE_ORDER]           = CSCR_BYTE_ORDER_VAL;
          rd_d[CSCR_SYSRST_BIT]           = sys_reset_req_q;
        end
        CSCR_OFF_SLPC: begin
          rd_d[CSCR_WAKE_ANY_BIT] = wake_any_pending_q;
          rd_d[CSCR_DEEP_BIT]     = deep_sleep_select_q;
          rd_d[CSCR_ONEXIT_BIT]   = sleep_after_handler_q;
        end
        CSCR_OFF_CFGC: begin
          rd_d = CSCR_CFG_VALUE;
        end
        default: begin
          rd_d = CSCR_RDATA_RESET;
        end
      endcase
    end
  end

  // Read data register, valid in the cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= CSCR_RDATA_RESET;
    end else begin
      reg_rdata_q <= rd_d;
    end
  end

  // Checks on the behaviour above
  a_key_guard: assert property (@(posedge clock) disable iff (!resetn)
    (reg_write && reg_addr == CSCR_OFF_RSTC && !key_ok && !sys_reset_req_q)
    |=> !sys_reset_req_q)
    else $error("write with bad key took effect");

  a_byte_order: assert property (@(posedge clock) disable iff (!resetn)
    (reg_read && reg_addr == CSCR_OFF_RSTC) |=> !reg_rdata_q[CSCR_BYTE_ORDER])
    else $error("byte order bit read nonzero");

  a_reset_request: assert property (@(posedge clock) disable iff (!resetn)
    (reg_write && reg_addr == CSCR_OFF_RSTC && key_ok && reg_wdata[CSCR_SYSRST_BIT])
    |=> sys_reset_req_q [*2])
    else $error("reset request not raised and held");

  a_halt_clear: assert property (@(posedge clock) disable iff (!resetn)
    $rose(sys_reset_req_q) |-> halt_flag_clear_q)
    else $error("halt flag not cleared with reset request");

  a_clear_source: assert property (@(posedge clock) disable iff (!resetn)
    exc_clear_q |-> $past(reg_from_debug && core_halted) ##1 (!exc_clear_q || $past(clr_req)))
    else $error("clear-active set outside halted debug or stuck");

  a_clear_effect: assert property (@(posedge clock) disable iff (!resetn)
    exc_clear_q |-> (exception_number_status_q == CSCR_EXC_NUM_RESET))
    else $error("exception number not zero after clear");

  a_disabled_ignored: assert property (@(posedge clock) disable iff (!resetn)
    (pwr_q == CSCR_WEVT && !wake_any_pending_q && ((wk.irq_rise & irq_enable) == '0)
     && !send_event_instr && !wk.ext_evt) |=> (pwr_q == CSCR_WEVT))
    else $error("woke on disabled interrupt");

  a_any_pending_wake: assert property (@(posedge clock) disable iff (!resetn)
    (pwr_q == CSCR_WEVT && wake_any_pending_q && (|wk.irq_rise))
    |=> (pwr_q == CSCR_RUN) && wake_q)
    else $error("no wake on pending interrupt");

  a_exit_sleep: assert property (@(posedge clock) disable iff (!resetn)
    (pwr_q == CSCR_RUN && handler_to_thread && sleep_after_handler_q && !wait_for_event_instr)
    |=> low_power_q && (deep_sleep_q == $past(deep_sleep_select_q)))
    else $error("no sleep on return to thread");

  a_deep_level: assert property (@(posedge clock) disable iff (!resetn)
    deep_sleep_q |-> low_power_q)
    else $error("deep sleep outside low power");

  a_unaligned_fault: assert property (@(posedge clock) disable iff (!resetn)
    (acc_valid && acc_size == CSCR_SIZE_HALF && acc_addr_lo[0]) |=> hard_fault_q)
    else $error("unaligned access without fault");

  a_config_word: assert property (@(posedge clock) disable iff (!resetn)
    (reg_read && reg_addr == CSCR_OFF_CFGC) |=> reg_rdata_q[CSCR_STK_ALIGN_BIT]
    && reg_rdata_q[CSCR_UNALIGN_BIT])
    else $error("configuration word fixed bits wrong");

endmodule // cscr_top

// ==== tb/cscr_sys_partner.sv ====
// Model of the outer reset controller and the debugger's halt flag
`timescale 1ns/1ns
module cscr_sys_partner #(
  parameter int RST_DELAY = 3,
  parameter int RST_LEN   = 2
)(
  // Clock and power-on reset
  input  wire logic clock,
  input  wire logic por_n,
  // From the block
  input  wire logic sys_reset_req_q,
  input  wire logic halt_flag_clear_q,
  // From the bench
  input  wire logic halt_req,
  // To the block
  output logic      sys_resetn,
  output logic      core_halted_q
);
  logic [3:0] wait_q;
  logic [3:0] hold_q;

  // Reset all but debug state a few cycles after the request
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      wait_q <= 4'h0;
      hold_q <= 4'h0;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end else if (sys_reset_req_q) begin
      wait_q <= (wait_q == 4'(RST_DELAY)) ? 4'h0 : wait_q + 4'h1;
      if (wait_q == 4'(RST_DELAY)) begin
        hold_q <= 4'(RST_LEN);
      end
    end
  end
  assign sys_resetn = por_n && (hold_q == 4'h0);

  // Halted flag survives system reset; the block's pulse clears it
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      core_halted_q <= 1'b0;
    end else if (halt_flag_clear_q) begin
      core_halted_q <= 1'b0;
    end else if (halt_req) begin
      core_halted_q <= 1'b1;
    end
  end
endmodule // cscr_sys_partner

// ==== tb/cscr_top_tb_top.sv ====
// Self-checking bench for the system control register block
`timescale 1ns/1ns
module cscr_top_tb_top;
  import cscr_pkg::*;
  logic        clock = 1'b0;
  logic        por_n = 1'b0;
  logic        resetn;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0, reg_read = 1'b0, reg_from_debug = 1'b0, halt_req = 1'b0;
  logic        core_halted, sys_reset_req_q, halt_flag_clear_q, exc_clear_q;
  logic        exc_num_load = 1'b0, exc_entry = 1'b0, exc_return = 1'b0, acc_valid = 1'b0;
  logic        wait_for_event_instr = 1'b0, send_event_instr = 1'b0, sleep_instr = 1'b0;
  logic        handler_to_thread = 1'b0, ext_event_pin = 1'b0;
  logic        wake_q, low_power_q, deep_sleep_q, saved_align_q, hard_fault_q, hit;
  logic [8:0]  exc_num_in = 9'h000;
  logic [8:0]  exception_number_status_q;
  logic [31:0] irq_pending = 32'h0, irq_enable = 32'h0, entry_sp = 32'h0, d, r;
  logic [31:0] return_frame_sp = 32'h0, return_saved_sts = 32'h0;
  logic [31:0] reg_rdata_q, frame_sp_q, restored_sp_q;
  logic [1:0]  acc_size = 2'h0, acc_addr_lo = 2'h0;
  logic [31:0] seed = 32'hD34D;
  int          err_count = 0, total_checks = 0, cycles = 0;

  cscr_top u_cscr_top (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_from_debug(reg_from_debug),
    .reg_rdata_q(reg_rdata_q), .core_halted(core_halted), .sys_reset_req_q(sys_reset_req_q),
    .halt_flag_clear_q(halt_flag_clear_q), .exc_clear_q(exc_clear_q),
    .exc_num_load(exc_num_load), .exc_num_in(exc_num_in),
    .exception_number_status_q(exception_number_status_q), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .wait_for_event_instr(wait_for_event_instr),
    .send_event_instr(send_event_instr), .ext_event_pin(ext_event_pin),
    .sleep_instr(sleep_instr), .handler_to_thread(handler_to_thread), .wake_q(wake_q),
    .low_power_q(low_power_q), .deep_sleep_q(deep_sleep_q), .exc_entry(exc_entry),
    .entry_sp(entry_sp), .exc_return(exc_return), .return_frame_sp(return_frame_sp),
    .return_saved_sts(return_saved_sts), .frame_sp_q(frame_sp_q),
    .saved_align_q(saved_align_q), .restored_sp_q(restored_sp_q), .acc_valid(acc_valid),
    .acc_size(acc_size), .acc_addr_lo(acc_addr_lo), .hard_fault_q(hard_fault_q));

  cscr_sys_partner u_cscr_sys_partner (
    .clock(clock), .por_n(por_n), .sys_reset_req_q(sys_reset_req_q),
    .halt_flag_clear_q(halt_flag_clear_q), .halt_req(halt_req), .sys_resetn(resetn),
    .core_halted_q(core_halted));

  // Clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      summarize();
    end
  end

  // Random source and expectations
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic exp_fault(input logic [1:0] s, input logic [1:0] a);
    return (s == 2'h0) ? 1'b0 : (s == 2'h1) ? a[0] : (a != 2'h0);
  endfunction

  // Compare, bus cycles and pulses
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic dbg);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_from_debug <= dbg;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_from_debug <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata_q;
  endtask
  task automatic pls(input int k);
    @(posedge clock);
    case (k)
      0: wait_for_event_instr <= 1'b1;
      1: send_event_instr <= 1'b1;
      2: sleep_instr <= 1'b1;
      3: handler_to_thread <= 1'b1;
      4: exc_num_load <= 1'b1;
      5: exc_entry <= 1'b1;
      6: exc_return <= 1'b1;
      default: acc_valid <= 1'b1;
    endcase
    @(posedge clock);
    {wait_for_event_instr, send_event_instr, sleep_instr, handler_to_thread} <= 4'h0;
    {exc_num_load, exc_entry, exc_return, acc_valid} <= 4'h0;
    #1;
  endtask
  task automatic wait_wake();
    hit = 1'b0;
    repeat (6) begin
      @(posedge clock);
      #1;
      if (wake_q === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    por_n <= 1'b1;
    wr(CSCR_OFF_CFGC, rnd(), 1'b0);
    rd(CSCR_OFF_CFGC, d);
    chk("cfg word", d, (32'h1 << CSCR_STK_ALIGN_BIT) | (32'h1 << CSCR_UNALIGN_BIT));
    rd(16'hED18, d);
    chk("unmapped", d, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(CSCR_OFF_SLPC, r, 1'b0);
      rd(CSCR_OFF_SLPC, d);
      chk("sleep word", d, r & 32'h0000_0016);
    end
    wr(CSCR_OFF_RSTC, {16'h05FB, 16'h0004}, 1'b0);
    chk("bad key", sys_reset_req_q, 32'h0);
    rd(CSCR_OFF_RSTC, d);
    chk("reset word", d, 32'h0000_0000);
    $display("test registers done");
    exc_num_in <= 9'h0A3;
    pls(4);
    wr(CSCR_OFF_RSTC, {CSCR_WRITE_KEY, 16'h0002}, 1'b0);
    chk("clr no dbg", exc_clear_q, 32'h0);
    wr(CSCR_OFF_RSTC, {CSCR_WRITE_KEY, 16'h0002}, 1'b1);
    chk("clr no halt", exception_number_status_q, 32'h0A3);
    halt_req <= 1'b1;
    pls(4);
    halt_req <= 1'b0;
    wr(CSCR_OFF_RSTC, {CSCR_WRITE_KEY, 16'h0002}, 1'b1);
    chk("clr pulse", exc_clear_q, 32'h1);
    chk("exc num", exception_number_status_q, 32'h0);
    rd(CSCR_OFF_RSTC, d);
    chk("clr self", {exc_clear_q, d[1]}, 32'h0);
    $display("test clear active done");
    wr(CSCR_OFF_SLPC, 32'h0000_0004, 1'b0);
    pls(2);
    chk("deep", {low_power_q, deep_sleep_q}, 32'h3);
    r = rnd() & 32'h1F;
    irq_enable <= 32'h1 << r;
    irq_pending <= 32'h1 << r;
    wait_wake();
    chk("sleep wake", {hit, low_power_q}, 32'h2);
    irq_pending <= 32'h0;
    wr(CSCR_OFF_SLPC, 32'h0, 1'b0);
    // The interrupt that ended the sleep was held; the first wait eats it
    pls(0);
    chk("sleep latched", {wake_q, low_power_q}, 32'h2);
    pls(0);
    chk("wait light", {low_power_q, deep_sleep_q}, 32'h2);
    pls(1);
    chk("send wake", {wake_q, low_power_q}, 32'h2);
    irq_enable <= 32'h0;
    pls(0);
    irq_pending <= 32'h1 << r;
    wait_wake();
    chk("disabled", {hit, low_power_q}, 32'h1);
    irq_pending <= 32'h0;
    irq_enable <= 32'h1 << r;
    @(posedge clock);
    irq_pending <= 32'h1 << r;
    wait_wake();
    chk("enabled", hit, 32'h1);
    {irq_pending, irq_enable} <= 64'h0;
    wr(CSCR_OFF_SLPC, 32'h0000_0010, 1'b0);
    pls(0);
    irq_pending <= 32'h1 << r;
    wait_wake();
    chk("wake any", hit, 32'h1);
    irq_pending <= 32'h0;
    wr(CSCR_OFF_SLPC, 32'h0, 1'b0);
    pls(1);
    pls(0);
    chk("latched", {wake_q, low_power_q}, 32'h2);
    pls(0);
    ext_event_pin <= 1'b1;
    wait_wake();
    chk("ext event", hit, 32'h1);
    ext_event_pin <= 1'b0;
    wr(CSCR_OFF_SLPC, 32'h0000_0002, 1'b0);
    pls(3);
    chk("on exit", low_power_q, 32'h1);
    irq_enable <= 32'h1;
    irq_pending <= 32'h1;
    wait_wake();
    {irq_pending, irq_enable} <= 64'h0;
    wr(CSCR_OFF_SLPC, 32'h0, 1'b0);
    pls(3);
    chk("no exit", low_power_q, 32'h0);
    $display("test power done");
    // Exception entry and return with random stack pointers
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      entry_sp <= r;
      pls(5);
      chk("frame", frame_sp_q, {r[31:3], 3'h0});
      chk("pad", saved_align_q, r[2]);
      return_frame_sp <= {r[31:3], 3'h0};
      return_saved_sts <= {22'h0, r[2], 9'h000};
      pls(6);
      chk("restore", restored_sp_q, {r[31:3], r[2], 2'h0});
    end
    for (int i = 0; i < 16; i++) begin
      acc_size <= 2'(i >> 2);
      acc_addr_lo <= 2'(i);
      pls(7);
      chk("fault", hard_fault_q, exp_fault(2'(i >> 2), 2'(i)));
    end
    $display("test alignment done");
    wr(CSCR_OFF_RSTC, {CSCR_WRITE_KEY, 16'h0004}, 1'b0);
    chk("reset req", {sys_reset_req_q, halt_flag_clear_q}, 32'h3);
    pls(1);
    chk("halt clear", {halt_flag_clear_q, core_halted}, 32'h0);
    repeat (10) @(posedge clock);
    rd(CSCR_OFF_RSTC, d);
    chk("after reset", sys_reset_req_q, 32'h0);
    chk("reset read", d, 32'h0);
    $display("test reset request done");
    summarize();
  end
endmodule // cscr_top_tb_top
